//--- logic/hld_map.vh
`ifndef HLD_MAP_VH
`define HLD_MAP_VH

// ***************************************
// register byte offsets on the apb slave
// ***************************************
`define HLD_CTRL_OFS      8'h00
`define HLD_INSTR_OFS     8'h04
`define HLD_BASE_OFS      8'h08
`define HLD_OFFV_OFS      8'h0c
`define HLD_PC_OFS        8'h10
`define HLD_FLAGS_OFS     8'h14
`define HLD_STATUS_OFS    8'h18
`define HLD_RESULT_OFS    8'h1c
`define HLD_WBADDR_OFS    8'h20
`define HLD_MEMADDR_OFS   8'h24

// ***************************************
// control and status field positions
// ***************************************
`define HLD_CTRL_START    0
`define HLD_CTRL_WIDE     1
`define HLD_ST_BUSY       0
`define HLD_ST_DONE       1
`define HLD_ST_UNPRED     2
`define HLD_ST_NOP        3
`define HLD_ST_WBACK      4
`define HLD_ST_EXCL       5
`define HLD_ST_UNDEC      6
`define HLD_ST_SHCARRY    7

// ***************************************
// reset values
// ***************************************
`define HLD_RST_WORD      32'h0000_0000
`define HLD_RST_INSTR     32'h0000_0000

// ***************************************
// instruction kinds and opcode patterns
// ***************************************
`define HLD_KIND_NONE     3'h0
`define HLD_KIND_EXCL     3'h1
`define HLD_KIND_IMM      3'h2
`define HLD_KIND_LIT      3'h3
`define HLD_KIND_REG      3'h4
`define HLD_OP16_IMM      5'h11
`define HLD_OP16_REG      7'h2d
`define HLD_OPW_EXCL      12'he8d
`define HLD_OPW_EXCL_LO   4'h5
`define HLD_OPW_WIDE_OFFSET_FIELD     12'hf8b
`define HLD_OPW_NARROW    12'hf83
`define HLD_OPW_LIT_HI    8'hf8
`define HLD_OPW_LIT_LO    7'h3f
`define HLD_REG_SP        4'hd
`define HLD_REG_ONES      4'hf

// ***************************************
// timing: apb wait states per access (access phase lasts two cycles)
// ***************************************
`define HLD_APB_WAIT      1

`endif

//--- logic/hld_decode.v
`include "hld_map.vh"

// ***************************************
// combinational decode of one halfword load
// ***************************************
module hld_decode (
   // instruction in
   input  wire [31:0] instr_in,      // 16-bit form sits in [15:0]
   input  wire        wide_in,       // 32-bit form flag
   // decoded fields
   output reg  [2:0]  kind_out,      // instruction kind
   output reg  [3:0]  dest_out,      // destination_field
   output reg  [3:0]  base_out,      // base_field
   output reg  [3:0]  offreg_out,    // offset_register_field
   output reg  [11:0] imm_out,       // zero-extended offset
   output reg  [1:0]  shift_out,     // shift_amount_field
   output reg         index_out,     // pre-indexed
   output reg         add_out,       // add, not subtract
   output reg         wback_out,     // base writeback
   output reg         hint_out,      // executes as no-op
   output reg         unpred_out     // unpredictable operands
);

   // one flat priority chain; 16-bit forms checked first, then exclusive, then literal, then the other base-register forms
   always @* begin
      kind_out   = `HLD_KIND_NONE;
      dest_out   = instr_in[15:12];
      base_out   = instr_in[19:16];
      offreg_out = instr_in[3:0];
      imm_out    = 12'h000;
      shift_out  = 2'h0;
      index_out  = 1'b1;
      add_out    = 1'b1;
      wback_out  = 1'b0;
      hint_out   = 1'b0;
      unpred_out = 1'b0;
      if (!wide_in) begin
         dest_out = {1'b0, instr_in[2:0]};
         base_out = {1'b0, instr_in[5:3]};
         if (instr_in[15:11] == `HLD_OP16_IMM) begin
            // short_offset_field doubled, pre-indexed, no writeback
            kind_out = `HLD_KIND_IMM;
            imm_out  = {6'h00, instr_in[10:6], 1'b0};
         end else if (instr_in[15:9] == `HLD_OP16_REG) begin
            kind_out   = `HLD_KIND_REG;
            offreg_out = {1'b0, instr_in[8:6]};
         end
      end else if (instr_in[31:20] == `HLD_OPW_EXCL && instr_in[7:4] == `HLD_OPW_EXCL_LO) begin
         kind_out   = `HLD_KIND_EXCL;
         unpred_out = (dest_out == `HLD_REG_SP) || (dest_out == `HLD_REG_ONES) ||
                      (base_out == `HLD_REG_ONES);
      end else if (instr_in[31:24] == `HLD_OPW_LIT_HI && instr_in[22:16] == `HLD_OPW_LIT_LO) begin
         // pc-relative: magnitude plus direction bit
         kind_out   = `HLD_KIND_LIT;
         add_out    = instr_in[23];
         imm_out    = instr_in[11:0];
         hint_out   = (dest_out == `HLD_REG_ONES);
         unpred_out = (dest_out == `HLD_REG_SP);
      end else if (instr_in[31:20] == `HLD_OPW_WIDE_OFFSET_FIELD) begin
         kind_out   = `HLD_KIND_IMM;
         imm_out    = instr_in[11:0];
         hint_out   = (dest_out == `HLD_REG_ONES);
         unpred_out = (dest_out == `HLD_REG_SP);
      end else if (instr_in[31:20] == `HLD_OPW_NARROW && instr_in[11]) begin
         kind_out  = `HLD_KIND_IMM;
         index_out = instr_in[10];
         add_out   = instr_in[9];
         wback_out = instr_in[8];
         imm_out   = {4'h0, instr_in[7:0]};
         hint_out  = (dest_out == `HLD_REG_ONES) && instr_in[10] && !instr_in[9] && !instr_in[8];
         // unprivileged and non-indexed-no-writeback patterns are not ours
         if ((instr_in[10] && instr_in[9] && !instr_in[8]) || (!instr_in[10] && !instr_in[8])) begin
            kind_out = `HLD_KIND_NONE;
         end
      end else if (instr_in[31:20] == `HLD_OPW_NARROW && instr_in[11:6] == 6'h00) begin
         kind_out   = `HLD_KIND_REG;
         shift_out  = instr_in[5:4];
         hint_out   = (dest_out == `HLD_REG_ONES);
         unpred_out = (dest_out == `HLD_REG_SP) || (offreg_out == `HLD_REG_SP) ||
                      (offreg_out == `HLD_REG_ONES);
      end
   end

endmodule

//--- logic/hld_agu.v
`include "hld_map.vh"

// ***************************************
// address generation and offset shifter
// ***************************************
module hld_agu (
   // operand values
   input  wire [31:0] base_val_in,   // base register value
   input  wire [31:0] offv_val_in,   // offset register value
   input  wire [31:0] pc_val_in,     // program counter value
   input  wire        carry_in,      // carry_flag
   // decoded controls
   input  wire [2:0]  kind_in,       // instruction kind
   input  wire [11:0] imm_in,        // zero-extended offset
   input  wire [1:0]  shift_in,      // left shift 0..3
   input  wire        index_in,      // pre-indexed
   input  wire        add_in,        // add, not subtract
   // results
   output reg  [31:0] addr_out,      // memory address
   output reg  [31:0] offs_addr_out, // writeback address
   output reg         shcarry_out    // shifter carry out
);

   reg [31:0] base_w;                // selected base
   reg [31:0] off_w;                 // selected offset

   // general left shifter, then base select and add/subtract
   always @* begin
      // zero shift passes the incoming carry through unchanged
      case (shift_in)
         2'h1:    shcarry_out = offv_val_in[31];
         2'h2:    shcarry_out = offv_val_in[30];
         2'h3:    shcarry_out = offv_val_in[29];
         default: shcarry_out = carry_in;
      endcase
      base_w = base_val_in;
      off_w  = {20'h00000, imm_in};
      case (kind_in)
         `HLD_KIND_LIT: begin
            base_w = {pc_val_in[31:2], 2'b00};
         end
         `HLD_KIND_REG: begin
            off_w = offv_val_in << shift_in;
         end
         `HLD_KIND_EXCL: begin
            off_w = 32'h0000_0000;
         end
         default: begin
            off_w = {20'h00000, imm_in};
         end
      endcase
      offs_addr_out = add_in ? (base_w + off_w) : (base_w - off_w);
      addr_out      = index_in ? offs_addr_out : base_w;
   end

endmodule

//--- logic/hld_top.v
`include "hld_map.vh"

module hld_top #(
   parameter AW = 8                  // apb address width
) (
   // clock and reset
   input  wire        clk_in,        // core clock
   input  wire        sys_rst_in,    // synchronous, active high
   // apb slave
   input  wire        psel_in,       // select
   input  wire        penable_in,    // access phase
   input  wire        pwrite_in,     // write direction
   input  wire [AW-1:0] paddr_in,    // byte address
   input  wire [31:0] pwdata_in,     // write data
   output reg  [31:0] prdata_out,    // read data
   output reg         pready_out,    // transfer done
   output reg         pslverr_out,   // unmapped address
   // load path to memory
   output reg         mem_req_out,   // read request, held to ack
   output reg  [31:0] mem_addr_out,  // halfword address
   output reg         mem_aligned_out, // aligned_read when high
   output reg         mem_excl_out,  // arm_exclusive_monitors, 2 bytes
   input  wire        mem_ack_in,    // read data valid
   input  wire [15:0] mem_rdata_in,  // halfword read data
   // register file write ports
   output reg         rf_wb_we_out,  // base writeback pulse
   output reg  [3:0]  rf_wb_idx_out, // base register index
   output reg  [31:0] rf_wb_data_out, // new base value
   output reg         rf_we_out,     // destination write pulse
   output reg  [3:0]  rf_idx_out,    // destination index
   output reg  [31:0] rf_data_out    // zero-extended data
);

   // ***************************************
   // state encodings
   // ***************************************
   localparam [1:0] ST_IDLE = 2'h0;  // waiting for start
   localparam [1:0] ST_READ = 2'h1;  // request held to memory
   localparam [1:0] ST_LOAD = 2'h2;  // destination write cycle

   // ***************************************
   // storage
   // ***************************************
   reg  [31:0] instr_q;              // instruction word
   reg         wide_q;               // 32-bit form selected
   reg  [31:0] base_q;               // base register value
   reg  [31:0] offv_q;               // offset register value
   reg  [31:0] pc_q;                 // pc value
   reg         carry_q;              // carry_flag
   reg  [1:0]  state_q;              // sequencer state
   reg         done_q;               // last op finished
   reg         unpred_q;             // unpredictable seen
   reg         nop_q;                // executed as hint
   reg         wback_q;              // writeback pending/done
   reg         excl_q;               // exclusive op
   reg         undec_q;              // not a halfword load
   reg         shcarry_q;            // shifter carry out
   reg  [3:0]  dest_q;               // captured destination
   reg  [3:0]  basei_q;              // captured base index
   reg  [31:0] result_q;             // loaded data
   reg  [31:0] wbaddr_q;             // captured writeback address

   // ***************************************
   // decode and address generation
   // ***************************************
   wire [2:0]  kind_w;               // instruction kind
   wire [3:0]  dest_w;               // destination index
   wire [3:0]  base_w;               // base index
   wire [11:0] imm_w;                // offset immediate
   wire [1:0]  shift_w;              // shift amount
   wire        index_w;              // pre-indexed
   wire        add_w;                // add direction
   wire        wbk_w;                // writeback
   wire        hint_w;               // no-op alias
   wire        unpred_w;             // unpredictable
   wire [31:0] addr_w;               // memory address
   wire [31:0] offs_w;               // writeback address
   wire        shc_w;                // shifter carry

   hld_decode u_dec (
      .instr_in   (instr_q),
      .wide_in    (wide_q),
      .kind_out   (kind_w),
      .dest_out   (dest_w),
      .base_out   (base_w),
      .offreg_out (),
      .imm_out    (imm_w),
      .shift_out  (shift_w),
      .index_out  (index_w),
      .add_out    (add_w),
      .wback_out  (wbk_w),
      .hint_out   (hint_w),
      .unpred_out (unpred_w)
   );

   hld_agu u_agu (
      .base_val_in   (base_q),
      .offv_val_in   (offv_q),
      .pc_val_in     (pc_q),
      .carry_in      (carry_q),
      .kind_in       (kind_w),
      .imm_in        (imm_w),
      .shift_in      (shift_w),
      .index_in      (index_w),
      .add_in        (add_w),
      .addr_out      (addr_w),
      .offs_addr_out (offs_w),
      .shcarry_out   (shc_w)
   );

   // ***************************************
   // apb decode
   // ***************************************
   wire [7:0] ofs_w = {{(8-AW){1'b0}}, paddr_in} ;   // byte offset
   wire       acc_w = psel_in & penable_in;          // access phase
   wire       wr_w  = acc_w & pready_out & pwrite_in; // write commits here
   wire       start_w = wr_w && (ofs_w == `HLD_CTRL_OFS) &&
                        pwdata_in[`HLD_CTRL_START] && (state_q == ST_IDLE);
   wire [31:0] status_w = {16'h0000, basei_q, dest_q, shcarry_q, undec_q, excl_q,
                           wback_q, nop_q, unpred_q, done_q, (state_q != ST_IDLE)};
   reg  [31:0] rd_w;                 // read mux
   reg         hit_w;                // address mapped

   // read mux; unmapped reads zero with slave error
   always @* begin
      hit_w = 1'b1;
      case (ofs_w)
         `HLD_CTRL_OFS:    rd_w = {30'h0, wide_q, 1'b0};
         `HLD_INSTR_OFS:   rd_w = instr_q;
         `HLD_BASE_OFS:    rd_w = base_q;
         `HLD_OFFV_OFS:    rd_w = offv_q;
         `HLD_PC_OFS:      rd_w = pc_q;
         `HLD_FLAGS_OFS:   rd_w = {31'h0, carry_q};
         `HLD_STATUS_OFS:  rd_w = status_w;
         `HLD_RESULT_OFS:  rd_w = result_q;
         `HLD_WBADDR_OFS:  rd_w = wbaddr_q;
         `HLD_MEMADDR_OFS: rd_w = mem_addr_out;
         default: begin
            rd_w  = 32'h0000_0000;
            hit_w = 1'b0;
         end
      endcase
   end

   // one wait state: pready rises on the second access cycle
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= `HLD_RST_WORD;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= acc_w & ~pready_out;
         prdata_out  <= (acc_w & ~pready_out & ~pwrite_in) ? rd_w : 32'h0000_0000;
         pslverr_out <= acc_w & ~pready_out & ~hit_w;
      end
   end

   // operand registers; writable any time, captured at start
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         instr_q <= `HLD_RST_INSTR;
         wide_q  <= 1'b0;
         base_q  <= `HLD_RST_WORD;
         offv_q  <= `HLD_RST_WORD;
         pc_q    <= `HLD_RST_WORD;
         carry_q <= 1'b0;
      end else if (wr_w) begin
         case (ofs_w)
            `HLD_CTRL_OFS:  wide_q  <= pwdata_in[`HLD_CTRL_WIDE];
            `HLD_INSTR_OFS: instr_q <= pwdata_in;
            `HLD_BASE_OFS:  base_q  <= pwdata_in;
            `HLD_OFFV_OFS:  offv_q  <= pwdata_in;
            `HLD_PC_OFS:    pc_q    <= pwdata_in;
            `HLD_FLAGS_OFS: carry_q <= pwdata_in[0];
            default:        carry_q <= carry_q;
         endcase
      end
   end

   // ***************************************
   // execution sequencer
   // ***************************************
   // start uses the wide flag already stored; set it in an earlier write
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q         <= ST_IDLE;
         done_q          <= 1'b0;
         unpred_q        <= 1'b0;
         nop_q           <= 1'b0;
         wback_q         <= 1'b0;
         excl_q          <= 1'b0;
         undec_q         <= 1'b0;
         shcarry_q       <= 1'b0;
         dest_q          <= 4'h0;
         basei_q         <= 4'h0;
         result_q        <= `HLD_RST_WORD;
         wbaddr_q        <= `HLD_RST_WORD;
         mem_req_out     <= 1'b0;
         mem_addr_out    <= `HLD_RST_WORD;
         mem_aligned_out <= 1'b0;
         mem_excl_out    <= 1'b0;
         rf_wb_we_out    <= 1'b0;
         rf_wb_idx_out   <= 4'h0;
         rf_wb_data_out  <= `HLD_RST_WORD;
         rf_we_out       <= 1'b0;
         rf_idx_out      <= 4'h0;
         rf_data_out     <= `HLD_RST_WORD;
      end else begin
         // write ports pulse for one cycle only
         rf_wb_we_out <= 1'b0;
         rf_we_out    <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start_w) begin
                  done_q    <= 1'b0;
                  dest_q    <= dest_w;
                  basei_q   <= base_w;
                  wbaddr_q  <= offs_w;
                  shcarry_q <= shc_w;
                  excl_q    <= (kind_w == `HLD_KIND_EXCL);
                  undec_q   <= (kind_w == `HLD_KIND_NONE);
                  unpred_q  <= unpred_w;
                  nop_q     <= hint_w & ~unpred_w;
                  wback_q   <= wbk_w;
                  if ((kind_w == `HLD_KIND_NONE) || unpred_w || hint_w) begin
                     // no access, no register update: finishes at once
                     done_q  <= 1'b1;
                     wback_q <= 1'b0;
                  end else begin
                     mem_req_out     <= 1'b1;
                     mem_addr_out    <= addr_w;
                     mem_aligned_out <= (kind_w == `HLD_KIND_EXCL);
                     mem_excl_out    <= (kind_w == `HLD_KIND_EXCL);
                     state_q         <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               // request stays up until memory answers
               if (mem_ack_in) begin
                  mem_req_out  <= 1'b0;
                  mem_excl_out <= 1'b0;
                  result_q     <= {16'h0000, mem_rdata_in};
                  rf_wb_we_out   <= wback_q;
                  rf_wb_idx_out  <= basei_q;
                  rf_wb_data_out <= wbaddr_q;
                  state_q      <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               // destination written one cycle after the base writeback
               rf_we_out   <= 1'b1;
               rf_idx_out  <= dest_q;
               rf_data_out <= result_q;
               done_q      <= 1'b1;
               state_q     <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

//--- verification/hld_top_props.sv
// ****
// port checker for the halfword load block
// ****
module hld_top_props #(
   parameter AW = 8
) (
   // watched ports, grouped to keep it short
   input wire logic        clk_in, sys_rst_in, psel_in, penable_in, pready_out, pslverr_out,
   input wire logic [31:0] prdata_out, mem_addr_out, rf_data_out,
   input wire logic        mem_req_out, mem_aligned_out, mem_excl_out, mem_ack_in,
   input wire logic [15:0] mem_rdata_in,
   input wire logic        rf_wb_we_out, rf_we_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   chk_apb_wait: assert property ($rose(psel_in && penable_in) |-> !pready_out ##1 pready_out)
      else $error("apb wait state wrong");
   chk_err_qual: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside ready");
   chk_req_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
      else $error("request dropped early");
   chk_req_drop: assert property (mem_req_out && mem_ack_in |=> !mem_req_out && !mem_excl_out)
      else $error("request kept after ack");
   chk_excl_align: assert property (mem_excl_out |-> mem_req_out && mem_aligned_out)
      else $error("exclusive read not aligned");
   chk_zero_ext: assert property (mem_req_out && mem_ack_in |=> ##1 rf_we_out && rf_data_out == {16'h0, $past(mem_rdata_in, 2)})
      else $error("destination data wrong");
   chk_wb_order: assert property (rf_wb_we_out |-> $past(mem_req_out && mem_ack_in) ##1 rf_we_out)
      else $error("writeback out of order");
   chk_we_pulse: assert property (rf_we_out |=> !rf_we_out && !rf_wb_we_out)
      else $error("write pulse too long");
   chk_rst_quiet: assert property (disable iff (1'b0) sys_rst_in |=> !mem_req_out && !rf_we_out && !pready_out)
      else $error("outputs busy in reset");
endmodule
bind hld_top hld_top_props #(.AW(AW)) u_props (.*);

//--- verification/hld_mem_model.sv
// ****
// memory side of the load path
// ****
module hld_mem_model (
   input  wire logic        clk_in, slow, mem_req_out,
   input  wire logic [31:0] mem_addr_out,
   output logic             mem_ack_in = 1'b0,
   output logic [15:0]      mem_rdata_in = 16'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_q = 2'h0;  // stall cycles left
   // data toggles outside ack so stale values never match
   always @(posedge clk_in) begin
      mem_ack_in <= 1'b0;
      mem_rdata_in <= ~mem_rdata_in;
      if (!mem_req_out) wait_q <= slow ? 2'h3 : 2'h0;
      else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      else if (!mem_ack_in) begin
         mem_ack_in <= 1'b1;
         mem_rdata_in <= mem_addr_out[15:0] ^ 16'ha5c3;
      end
   end
endmodule

//--- verification/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, slow = 0;
   logic [7:0] paddr_in = 8'h0;
   logic [31:0] pwdata_in = 32'h0, prdata_out, mem_addr_out, rf_wb_data_out, rf_data_out;
   logic pready_out, pslverr_out, mem_req_out, mem_aligned_out, mem_excl_out, mem_ack_in;
   logic rf_wb_we_out, rf_we_out, er, m_ex, m_al, m_seen, w_seen;
   logic [3:0] rf_wb_idx_out, rf_idx_out, w_idx, d_idx;
   logic [15:0] mem_rdata_in;
   logic [31:0] rd, r, m_addr, w_data, d_data;
   int miscompares = 0, comparisons = 0, cycles = 0, seed = 91059;
   always #50 clk_in = ~clk_in;
   hld_top DUT (.*);
   hld_mem_model u_mem (.*);
   // capture what the load path did
   always @(posedge clk_in) begin
      if (mem_req_out && mem_ack_in) begin m_addr <= mem_addr_out; m_ex <= mem_excl_out; m_al <= mem_aligned_out; m_seen <= 1; end
      if (rf_wb_we_out) begin w_idx <= rf_wb_idx_out; w_data <= rf_wb_data_out; w_seen <= 1; end
      if (rf_we_out) begin d_idx <= rf_idx_out; d_data <= rf_data_out; end
      if (++cycles > 20000) begin miscompares++; close_out; end
   end
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin miscompares++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
      @(posedge clk_in) penable_in <= 1;
      do @(posedge clk_in); while (pready_out !== 1'b1 && ++n < 50);
      if (n >= 50) begin miscompares++; $display("mismatch at %0t: no pready", $time); end
      rd = prdata_out; er = pslverr_out;
      psel_in <= 0; penable_in <= 0;
      @(posedge clk_in);
   endtask
   // load operands, start, then compare against our own decode
   task automatic run(input logic [31:0] i, input logic w);
      logic [31:0] b, ov, pc, a, oa;
      logic [15:0] h1, h2;
      logic [3:0] t, n;
      logic u, nop, wb, ex, c, s;
      logic [1:0] sh;
      b = $random(seed); ov = $random(seed); pc = $random(seed); oa = b;
      c = pc[0]; sh = 2'h0;
      h1 = i[31:16]; h2 = i[15:0]; n = w ? h1[3:0] : {1'b0, i[5:3]}; t = w ? h2[15:12] : {1'b0, i[2:0]};
      u = 0; nop = 0; wb = 0; ex = 0; a = b;
      if (!w) a = (i[15:11] == 5'h11) ? b + {i[10:6], 1'b0} : b + ov;
      else if (h1[15:4] == 12'he8d) begin ex = 1; u = t == 13 || t == 15 || n == 15; end
      else if (h1[15:8] == 8'hf8 && h1[6:0] == 7'h3f) begin
         a = h1[7] ? {pc[31:2], 2'b0} + h2[11:0] : {pc[31:2], 2'b0} - h2[11:0];
         u = t == 13; nop = t == 15;
      end else if (h1[15:4] == 12'hf8b) begin a = b + h2[11:0]; u = t == 13; nop = t == 15; end
      else if (h2[11]) begin
         oa = h2[9] ? b + h2[7:0] : b - h2[7:0]; wb = h2[8];
         if (h2[10]) a = oa;
         nop = t == 15 && h2[10:8] == 3'b100;
      end else begin a = b + (ov << h2[5:4]); u = t == 13 || h2[3:0] == 13 || h2[3:0] == 15; nop = t == 15; end
      if (w && !(h1[15:4] == 12'he8d) && !(h1[15:8] == 8'hf8 && h1[6:0] == 7'h3f) && !(h1[15:4] == 12'hf8b) && !h2[11]) begin
         sh = h2[5:4];
      end
      s = (sh == 2'h0) ? c : ov[32 - sh];
      nop = nop & ~u;
      apb(1, 8'h08, b); apb(1, 8'h0c, ov); apb(1, 8'h10, pc); apb(1, 8'h14, {31'h0, c});
      apb(1, 8'h04, i); apb(1, 8'h00, {30'h0, w, 1'b0});
      m_seen = 0; w_seen = 0; d_data = 'x; slow <= $random(seed);
      apb(1, 8'h00, {30'h0, w, 1'b1});
      repeat (40) begin apb(0, 8'h18, 32'h0); if (rd[1:0] == 2'b10) break; end
      chk(rd[1:0], 2'b10);
      chk(rd[3:2], {nop, u});
      chk(rd[6:4], {1'b0, ex, wb});
      chk(rd[7], s);
      chk(m_seen, !(u | nop));
      if (!(u | nop)) begin
         chk(m_addr, a); chk({m_ex, m_al}, {ex, ex}); chk(d_idx, t);
         chk(d_data, {16'h0, a[15:0] ^ 16'ha5c3});
         chk(w_seen, wb); if (wb) begin chk(w_idx, n); chk(w_data, oa); end
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 0;
      @(posedge clk_in);
      apb(0, 8'h1c, 32'h0); chk(rd, 32'h0);
      apb(0, 8'h40, 32'h0); chk({31'h0, er}, 32'h1); chk(rd, 32'h0);
      run({16'h0, 5'h11, 5'h1f, 6'h3f}, 0);
      run({12'hf8b, 8'h21, 12'hfff}, 1);
      run({12'hf83, 8'h42, 6'h00, 2'h3, 4'h1}, 1);
      run({12'hf83, 8'h9f, 4'hc, 8'h12}, 1);
      repeat (60) begin
         r = $random(seed);
         case (r[31:29])
            0: run({16'h0, 5'h11, r[10:0]}, 0);
            1: run({16'h0, 7'h2d, r[8:0]}, 0);
            2: run({12'he8d, r[19:12], 12'hf5f}, 1);
            3: run({12'hf8b, r[19:12], r[11:0]}, 1);
            4: run({12'hf83, 1'b1, r[18:16], 1'b0, r[14:12], 1'b1, r[8] ? r[9] : 1'b1, r[8] & r[10], r[8:0]}, 1);
            5: run({12'hf83, r[19:12], 6'h0, r[5:0]}, 1);
            6: run({8'hf8, r[20], 7'h3f, r[15:0]}, 1);
            default: run({12'hf83, r[19:16], 8'hfc, r[7:0]}, 1);
         endcase
      end
      close_out;
   end
endmodule
